// ---- core/plt_pkg.sv ----
// Shared constants, encodings and carrier types of the load and thermal supervisor
package plt_pkg;
	// Time base
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_MS = 100;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int TICKS_PER_S = 1000 / TICK_MS;

	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_UL_CFG = 8'h04;
	localparam logic [7:0] A_OL_CFG = 8'h08;
	localparam logic [7:0] A_SENS_CFG = 8'h0C;
	localparam logic [7:0] A_SENS_LVL = 8'h10;
	localparam logic [7:0] A_STATUS = 8'h14;
	localparam logic [7:0] A_TEMP = 8'h18;
	localparam logic [7:0] A_THERM = 8'h1C;

	// Field positions
	localparam int CTRL_UL_EN = 0;
	localparam int CTRL_OL_EN = 1;
	localparam int CTRL_CASC = 2;
	localparam int CTRL_SENS_EN = 3;
	localparam int CTRL_STOP_TYPE = 4;
	localparam int CTRL_FRST = 8;
	localparam int CFG_THR = 8;
	localparam int UL_RESP = 16;
	localparam int OL_RESP = 20;
	localparam int SC_FILT = 4;
	localparam int SC_RESP = 8;
	localparam int SC_WGRP = 12;
	localparam int SL_WARN = 16;

	// Reset values and limits
	localparam logic [9:0] UL_DELAY_RST = 10'h03C;
	localparam logic [9:0] UL_THR_RST = 10'h03C;
	localparam logic [9:0] UL_THR_MIN = 10'h014;
	localparam logic [9:0] UL_THR_MAX = 10'h064;
	localparam logic [9:0] OL_DELAY_RST = 10'h00A;
	localparam logic [9:0] OL_THR_RST = 10'h050;
	localparam logic [9:0] OL_THR_MIN = 10'h032;
	localparam logic [9:0] OL_THR_MAX = 10'h12C;
	localparam logic [9:0] DELAY_MAX = 10'h064;
	localparam logic [9:0] HYST_PCT = 10'h00A;
	localparam logic [9:0] FILT_RST = 10'h000;
	localparam logic [9:0] FILT_MAX = 10'h00A;
	localparam logic signed [12:0] ERR_LVL_RST = 13'sh044C;
	localparam logic signed [12:0] WARN_LVL_RST = 13'sh0384;
	localparam logic signed [12:0] LVL_MIN = 13'sh1F6A;
	localparam logic signed [12:0] LVL_MAX = 13'sh07D0;
	localparam logic signed [12:0] TEMP_SHORT = 13'sh1EA2;
	localparam logic signed [12:0] TEMP_OPEN = 13'sh0812;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [2:0] {
		RESP_IGNORE = 3'h0,
		RESP_FREEWHEEL = 3'h1,
		RESP_PER_STOP = 3'h2,
		RESP_DECEL = 3'h3,
		RESP_BRAKE = 3'h4
	} plt_resp_t;

	typedef enum logic [1:0] {
		STOP_NONE = 2'h0,
		STOP_FREE = 2'h1,
		STOP_DECEL = 2'h2,
		STOP_BRAKE = 2'h3
	} plt_stop_t;

	typedef enum logic [1:0] {
		SENS_PTC = 2'h0,
		SENS_PT_2W = 2'h1,
		SENS_PT_3W = 2'h2
	} plt_sens_t;

	typedef enum logic [2:0] {
		TS_IDLE = 3'b001,
		TS_STOP = 3'b010,
		TS_LATCH = 3'b100
	} plt_tstate_t;

	// Process and sensor measurements from the analog front end
	typedef struct packed {
		logic [9:0] torque_pct;
		logic [9:0] current_pct;
		logic running;
		logic motor_active;
		logic stop_done;
		logic signed [12:0] sensor_temp;
		logic sensor_open;
		logic sensor_short;
		logic [8:0] motor_therm;
		logic [7:0] device_therm;
	} plt_meas_t;

	// Supervision results towards stop sequencing and digital outputs
	typedef struct packed {
		logic ul_err;
		logic ul_warn;
		logic ol_err;
		logic ol_warn;
		logic sens_err;
		logic sens_warn;
		plt_stop_t stop_cmd;
	} plt_alarm_t;
endpackage

// ---- core/plt_supervisor.sv ----
// Process load and sensor temperature supervisor with AHB-Lite register slave
`timescale 1ns/100ps
// Functional notes
// - Underload acts in running state after torque stays below threshold beyond delay.
// - Cascade operation forces underload and overload enables off.
// - Underload delay in whole seconds, default 60, expiry gives warning or error.
// - Underload timer clears when torque exceeds threshold plus ten percent, or when underload is disabled or the motor is not running.
// - Underload threshold 20 to 100 percent of nominal torque, default 60.
// - Underload response yes raises error, otherwise warning bit; default warning.
// - Overload acts while motor active after current exceeds threshold beyond delay.
// - Overload delay in whole seconds, default 10, expiry gives warning or error.
// - Overload timer clears when current drops below threshold minus ten percent, or when overload is disabled or the motor is not active.
// - Overload threshold 50 to 300 percent of nominal current, default 80.
// - Overload response yes raises error, otherwise warning bit; default warning.
// - Sensor supervision off by default; flags overheat, open and short circuit.
// - Sensor type selects PTC chain (default), two-wire or three-wire probe.
// - Sensor input low-pass filter up to ten seconds, default zero means none.
// - Thermal response: ignore, freewheel with error, normal stop, decel or brake.
// - Thermal decel and brake choices are kept apart from the normal stop type.
// - Error level default 110.0 C; resettable only below level minus ten percent.
// - Warning level default 90.0 C; produced only when assigned to a group.
// - Sensor warning resettable once temperature is below error level minus ten percent.
// - Displayed temperature forced to -35.0 C on short, 206.6 C on open.
// - Motor thermal state reported as percent of nominal.
// - Device heatsink thermal state reported as percent of nominal.
module plt_supervisor
	import plt_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
)(
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire plt_meas_t meas,
	output plt_alarm_t alarm
);
	localparam int TW = $clog2(TICK_CYC + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
	localparam logic [10:0] TMR_MAX = 11'h7FF;

	// Clamp an unsigned setting into its legal span
	function automatic logic [9:0] clamp_u(input logic [9:0] v, input logic [9:0] lo,
		input logic [9:0] hi);
		clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// Clamp a temperature level in tenths of a degree
	function automatic logic signed [12:0] clamp_t(input logic signed [12:0] v);
		clamp_t = (v < LVL_MIN) ? LVL_MIN : ((v > LVL_MAX) ? LVL_MAX : v);
	endfunction

	// Seconds to ticks
	function automatic logic [10:0] dly_ticks(input logic [9:0] d);
		dly_ticks = 11'(d * 10'(TICKS_PER_S));
	endfunction

	// Level minus ten percent of itself, the release point of sensor flags
	function automatic logic signed [12:0] hyst_lvl(input logic signed [12:0] l);
		hyst_lvl = l - (l / 13'sh000A);
	endfunction

	// Filter shift: time constant in ticks rounded to a power of two
	function automatic logic [2:0] filt_shift(input logic [9:0] s);
		case (s)
			10'h001: filt_shift = 3'h3;
			10'h002: filt_shift = 3'h4;
			10'h003, 10'h004: filt_shift = 3'h5;
			10'h005, 10'h006, 10'h007, 10'h008: filt_shift = 3'h6;
			default: filt_shift = 3'h7;
		endcase
	endfunction

	logic rst_s1_r, rst_n;
	logic [TW-1:0] tick_cnt_r;
	logic tick_r;
	logic wr_pend_r, rd_pend_r, hready_r, frst_r;
	logic [7:0] addr_r;
	logic [31:0] hrdata_r;
	logic ul_en_r, ol_en_r, casc_r, sens_en_r, ul_resp_r, ol_resp_r, wgrp_r;
	logic [9:0] ul_dly_r, ul_thr_r, ol_dly_r, ol_thr_r, filt_set_r;
	plt_stop_t stop_type_r;
	plt_resp_t sresp_r;
	plt_sens_t stype_r;
	logic signed [12:0] err_lvl_r, warn_lvl_r, disp_r;
	logic signed [16:0] filt_r;
	logic [10:0] ul_tmr_r, ol_tmr_r;
	logic ul_err_r, ul_warn_r, ol_err_r, ol_warn_r, sens_err_r, sens_warn_r;
	plt_stop_t stop_r;
	plt_tstate_t ts_r;
	logic [31:0] wd;
	logic wr_ctrl, ul_act, ol_act, ul_hit, ol_hit, sens_fault, sens_rel, warn_hit;
	logic signed [17:0] fdiff;

	// Asynchronous assertion, release through two flops
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	// Fixed supervision tick
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			tick_r <= (tick_cnt_r == TICK_LAST);
			tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? '0 : tick_cnt_r + 1'b1;
		end
	end

	// Bus slave: writes complete without wait, reads take one wait state
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			hready_r <= 1'b1;
			addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_r <= 1'b0;
			if (rd_pend_r)
			begin
				hrdata_r <= rd_mux(addr_r);
				hready_r <= 1'b1;
				rd_pend_r <= 1'b0;
			end
			if (hsel && hready && htrans[1])
			begin
				addr_r <= haddr[7:0];
				wr_pend_r <= hwrite && (hsize == HSIZE_WORD);
				if (!hwrite)
				begin
					rd_pend_r <= 1'b1;
					hready_r <= 1'b0;
				end
			end
		end
	end

	assign wd = hwdata;
	assign wr_ctrl = wr_pend_r && (addr_r == A_CTRL);

	// Read data; the wait state keeps a just-written value visible
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		case (a)
			A_CTRL: rd_mux = {26'h0, stop_type_r, sens_en_r, casc_r, ol_en_r, ul_en_r};
			// Threshold field is eight bits wide here, so the response sits right above it
			A_UL_CFG: rd_mux = {15'h0, ul_resp_r, ul_thr_r[7:0], ul_dly_r[7:0]};
			A_OL_CFG: rd_mux = {11'h0, ol_resp_r, 2'h0, ol_thr_r, 8'h00} | {24'h0, ol_dly_r[7:0]};
			A_SENS_CFG: rd_mux = {19'h0, wgrp_r, 1'b0, sresp_r, filt_set_r[3:0], 2'h0, stype_r};
			A_SENS_LVL: rd_mux = {3'h0, warn_lvl_r, 3'h0, err_lvl_r};
			A_STATUS: rd_mux = {18'h0, stop_r, 1'b0, ts_r, meas.sensor_short, meas.sensor_open,
				sens_warn_r, sens_err_r, ol_warn_r, ol_err_r, ul_warn_r, ul_err_r};
			A_TEMP: rd_mux = {19'h0, disp_r};
			A_THERM: rd_mux = {8'h00, meas.device_therm, 7'h00, meas.motor_therm};
			default: rd_mux = 32'h0000_0000;
		endcase
	endfunction

	// Control register and fault reset strobe
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ul_en_r <= 1'b0;
			ol_en_r <= 1'b0;
			casc_r <= 1'b0;
			sens_en_r <= 1'b0;
			stop_type_r <= STOP_FREE;
			frst_r <= 1'b0;
		end
		else
		begin
			frst_r <= wr_ctrl && wd[CTRL_FRST];
			if (wr_ctrl)
			begin
				casc_r <= wd[CTRL_CASC];
				sens_en_r <= wd[CTRL_SENS_EN];
				ul_en_r <= wd[CTRL_UL_EN] && !wd[CTRL_CASC];
				ol_en_r <= wd[CTRL_OL_EN] && !wd[CTRL_CASC];
				if (wd[CTRL_STOP_TYPE+1 -: 2] != STOP_NONE)
					stop_type_r <= plt_stop_t'(wd[CTRL_STOP_TYPE+1 -: 2]);
			end
		end
	end

	// Load supervision settings, writable only while enabled
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ul_dly_r <= UL_DELAY_RST;
			ul_thr_r <= UL_THR_RST;
			ul_resp_r <= 1'b0;
			ol_dly_r <= OL_DELAY_RST;
			ol_thr_r <= OL_THR_RST;
			ol_resp_r <= 1'b0;
		end
		else
		begin
			if (wr_pend_r && addr_r == A_UL_CFG && ul_en_r)
			begin
				ul_dly_r <= clamp_u({2'h0, wd[7:0]}, 10'h000, DELAY_MAX);
				ul_thr_r <= clamp_u({2'h0, wd[CFG_THR +: 8]}, UL_THR_MIN, UL_THR_MAX);
				ul_resp_r <= wd[UL_RESP];
			end
			if (wr_pend_r && addr_r == A_OL_CFG && ol_en_r)
			begin
				ol_dly_r <= clamp_u({2'h0, wd[7:0]}, 10'h000, DELAY_MAX);
				ol_thr_r <= clamp_u(wd[CFG_THR +: 10], OL_THR_MIN, OL_THR_MAX);
				ol_resp_r <= wd[OL_RESP];
			end
		end
	end

	// Sensor settings; the thermal response is its own field, apart from the stop type
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stype_r <= SENS_PTC;
			filt_set_r <= FILT_RST;
			sresp_r <= RESP_FREEWHEEL;
			wgrp_r <= 1'b0;
			err_lvl_r <= ERR_LVL_RST;
			warn_lvl_r <= WARN_LVL_RST;
		end
		else
		begin
			if (wr_pend_r && addr_r == A_SENS_CFG && sens_en_r)
			begin
				if (wd[1:0] <= SENS_PT_3W)
					stype_r <= plt_sens_t'(wd[1:0]);
				filt_set_r <= clamp_u({6'h00, wd[SC_FILT +: 4]}, 10'h000, FILT_MAX);
				if (wd[SC_RESP +: 3] <= RESP_BRAKE)
					sresp_r <= plt_resp_t'(wd[SC_RESP +: 3]);
				wgrp_r <= wd[SC_WGRP];
			end
			if (wr_pend_r && addr_r == A_SENS_LVL && sens_en_r)
			begin
				err_lvl_r <= clamp_t(wd[12:0]);
				warn_lvl_r <= clamp_t(wd[SL_WARN +: 13]);
			end
		end
	end

	assign ul_act = ul_en_r && meas.running;
	assign ol_act = ol_en_r && meas.motor_active;
	assign ul_hit = ul_act && (ul_tmr_r > dly_ticks(ul_dly_r));
	assign ol_hit = ol_act && (ol_tmr_r > dly_ticks(ol_dly_r));

	// Delay timers; between the threshold and the hysteresis band they hold
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ul_tmr_r <= 11'h000;
			ol_tmr_r <= 11'h000;
		end
		else
		begin
			if (!ul_act || meas.torque_pct > ul_thr_r + HYST_PCT)
				ul_tmr_r <= 11'h000;
			else if (tick_r && meas.torque_pct < ul_thr_r && ul_tmr_r != TMR_MAX)
				ul_tmr_r <= ul_tmr_r + 11'h001;
			if (!ol_act || meas.current_pct < ol_thr_r - HYST_PCT)
				ol_tmr_r <= 11'h000;
			else if (tick_r && meas.current_pct > ol_thr_r && ol_tmr_r != TMR_MAX)
				ol_tmr_r <= ol_tmr_r + 11'h001;
		end
	end

	// Load flags are sticky; a new detection wins over a fault reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ul_err_r <= 1'b0;
			ul_warn_r <= 1'b0;
			ol_err_r <= 1'b0;
			ol_warn_r <= 1'b0;
		end
		else
		begin
			ul_err_r <= (ul_hit && ul_resp_r) || (ul_err_r && !frst_r);
			ul_warn_r <= (ul_hit && !ul_resp_r) || (ul_warn_r && !frst_r);
			ol_err_r <= (ol_hit && ol_resp_r) || (ol_err_r && !frst_r);
			ol_warn_r <= (ol_hit && !ol_resp_r) || (ol_warn_r && !frst_r);
		end
	end

	// First-order low pass in 1/160 degree steps, updated per tick
	assign fdiff = 18'(signed'({meas.sensor_temp, 4'h0})) - 18'(filt_r);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			filt_r <= 17'sh00000;
			disp_r <= 13'sh0000;
		end
		else
		begin
			if (filt_set_r == 10'h000)
				filt_r <= {meas.sensor_temp, 4'h0};
			else if (tick_r)
				filt_r <= filt_r + 17'(fdiff >>> filt_shift(filt_set_r));
			if (meas.sensor_short)
				disp_r <= TEMP_SHORT;
			else if (meas.sensor_open)
				disp_r <= TEMP_OPEN;
			else
				disp_r <= filt_r[16:4];
		end
	end

	assign sens_fault = meas.sensor_open || meas.sensor_short || (disp_r >= err_lvl_r);
	assign sens_rel = !meas.sensor_open && !meas.sensor_short && (disp_r <= hyst_lvl(err_lvl_r));
	assign warn_hit = sens_en_r && wgrp_r && (stype_r != SENS_PTC) && (disp_r >= warn_lvl_r);

	// Thermal response sequencing and sensor error flag
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ts_r <= TS_IDLE;
			stop_r <= STOP_NONE;
			sens_err_r <= 1'b0;
		end
		else
		begin
			case (ts_r)
				TS_IDLE:
					if (sens_en_r && sens_fault)
					begin
						case (sresp_r)
							RESP_FREEWHEEL:
							begin
								sens_err_r <= 1'b1;
								stop_r <= STOP_FREE;
								ts_r <= TS_LATCH;
							end
							RESP_PER_STOP:
							begin
								stop_r <= stop_type_r;
								ts_r <= TS_LATCH;
							end
							RESP_DECEL:
							begin
								stop_r <= STOP_DECEL;
								ts_r <= TS_STOP;
							end
							RESP_BRAKE:
							begin
								stop_r <= STOP_BRAKE;
								ts_r <= TS_STOP;
							end
							default: ts_r <= TS_IDLE;
						endcase
					end
				TS_STOP:
					if (meas.stop_done)
					begin
						sens_err_r <= 1'b1;
						ts_r <= TS_LATCH;
					end
				TS_LATCH:
					if (frst_r && sens_rel)
					begin
						sens_err_r <= 1'b0;
						stop_r <= STOP_NONE;
						ts_r <= TS_IDLE;
					end
				default: ts_r <= TS_IDLE;
			endcase
		end
	end

	// Sensor warning; release only below the error level less ten percent
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sens_warn_r <= 1'b0;
		else
			sens_warn_r <= warn_hit || (sens_warn_r && !(frst_r && sens_rel));
	end

	assign hreadyout = hready_r;
	assign hrdata = hrdata_r;
	assign hresp = 1'b0;
	assign alarm = {ul_err_r, ul_warn_r, ol_err_r, ol_warn_r, sens_err_r, sens_warn_r, stop_r};
endmodule // plt_supervisor

// ---- verification/plt_supervisor_asserts.sv ----
// Bus and supervision checker bound to the supervisor top
`timescale 1ns/100ps
module plt_supervisor_asserts
	import plt_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
)(
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire plt_meas_t meas,
	input wire plt_alarm_t alarm
);
	logic ctl_ph_r;
	logic ul_en_r;
	logic ol_en_r;
	logic sens_en_r;
	logic [2:0] frst_r;
	wire take = hsel & hready & htrans[1];
	wire ctl_wr = ctl_ph_r & hready;
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// Shadow of the enables, so gating is judged from the bus alone; cascade wins
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			ctl_ph_r <= 1'b0;
			ul_en_r <= 1'b0;
			ol_en_r <= 1'b0;
			sens_en_r <= 1'b0;
			frst_r <= 3'h0;
		end
		else
		begin
			if (hready)
				ctl_ph_r <= take & hwrite & (hsize == HSIZE_WORD) & (haddr[7:0] == A_CTRL);
			frst_r <= {frst_r[1:0], ctl_wr & hwdata[CTRL_FRST]};
			if (ctl_wr)
			begin
				ul_en_r <= hwdata[CTRL_UL_EN] & ~hwdata[CTRL_CASC];
				ol_en_r <= hwdata[CTRL_OL_EN] & ~hwdata[CTRL_CASC];
				sens_en_r <= hwdata[CTRL_SENS_EN];
			end
		end
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("bus response not OKAY");
	AST_RD_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	AST_WR_NOWAIT: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	AST_RD_HOLD: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved");
	AST_UL_GATE: assert property ($rose(alarm.ul_err || alarm.ul_warn) |-> $past(ul_en_r && meas.running))
		else $error("underload flag without enable and run");
	AST_OL_GATE: assert property ($rose(alarm.ol_err || alarm.ol_warn) |-> $past(ol_en_r && meas.motor_active))
		else $error("overload flag without enable and active motor");
	AST_UL_STICKY: assert property ($fell(alarm.ul_err || alarm.ul_warn) |-> frst_r != 3'h0)
		else $error("underload flag dropped without fault reset");
	AST_OL_STICKY: assert property ($fell(alarm.ol_err || alarm.ol_warn) |-> frst_r != 3'h0)
		else $error("overload flag dropped without fault reset");
	AST_SENS_GATE: assert property ($rose(alarm.sens_err || alarm.sens_warn) |-> $past(sens_en_r))
		else $error("sensor flag while supervision off");
	AST_SENS_HOLD: assert property ($fell(alarm.sens_err) |-> frst_r != 3'h0 && !meas.sensor_open && !meas.sensor_short)
		else $error("sensor error released early");
	AST_DECEL_END: assert property ($rose(alarm.sens_err) && alarm.stop_cmd inside {STOP_DECEL, STOP_BRAKE} |-> $past(meas.stop_done))
		else $error("sensor error before end of stop");
	cover property ($rose(alarm.ul_warn));
	cover property ($rose(alarm.ol_err));
	cover property ($rose(alarm.sens_err) && alarm.stop_cmd == STOP_BRAKE);
endmodule // plt_supervisor_asserts

bind plt_supervisor plt_supervisor_asserts #(.TICK_CYC(TICK_CYC)) u_plt_supervisor_asserts (
	.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .meas(meas), .alarm(alarm)
);

// ---- verification/plt_motor_model.sv ----
// Motor and sensor front end model facing the supervisor
`timescale 1ns/100ps
module plt_motor_model
	import plt_pkg::*;
#(
	parameter int STOP_CYC = 20
)(
	input wire logic clk,
	input wire logic resetn,
	input wire plt_meas_t set_meas,
	input wire plt_alarm_t alarm,
	output plt_meas_t meas
);
	int cnt_r;
	// Ramp-down time of a controlled stop; a slow motor needs a larger count
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			cnt_r <= 0;
		else if (alarm.stop_cmd inside {STOP_DECEL, STOP_BRAKE})
			cnt_r <= (cnt_r < STOP_CYC) ? cnt_r + 1 : cnt_r;
		else
			cnt_r <= 0;
	// Readings follow the bench, but a stopping motor leaves the run state
	always_comb
	begin
		meas = set_meas;
		meas.stop_done = (cnt_r == STOP_CYC);
		if (alarm.stop_cmd != STOP_NONE)
		begin
			meas.running = 1'b0;
			meas.motor_active = meas.stop_done ? 1'b0 : set_meas.motor_active;
		end
	end
endmodule // plt_motor_model

// ---- verification/plt_supervisor_test.sv ----
// Register-level test sequence for the load and thermal supervisor
`timescale 1ns/100ps
module plt_supervisor_test
	import plt_pkg::*;
;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	plt_meas_t mset = '0;
	plt_meas_t meas;
	plt_alarm_t alarm;
	int failures = 0;
	int compares = 0;
	logic [31:0] rv;
	logic [7:0] sexp [5] = '{8'h00, 8'h09, 8'h02, 8'h0A, 8'h0B};
	// 50 MHz clock
	always #10 clk = ~clk;
	// Short tick so a one second delay is a hundred cycles
	plt_supervisor #(.TICK_CYC(10)) u_plt_supervisor (
		.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .meas(meas), .alarm(alarm)
	);
	plt_motor_model u_plt_motor_model (
		.clk(clk), .resetn(resetn), .set_meas(mset), .alarm(alarm), .meas(meas)
	);
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic alm(input string nm, input logic [7:0] m, input logic [7:0] exp);
		check(nm, {24'h0, alarm & m}, {24'h0, exp});
	endtask
	// Waits for hready at the following edges; only the watchdog ends a hung slave
	task automatic wait_ready;
		@(posedge clk);
		while (hreadyout !== 1'b1)
			@(posedge clk);
	endtask
	// One single word transfer: address phase, then data phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		haddr <= {24'h0, a};
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rv = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		check(nm, rv, exp);
	endtask
	task automatic drive(input logic ol, input logic [9:0] v);
		if (ol)
			mset.current_pct <= v;
		else
			mset.torque_pct <= v;
	endtask
	// Count, pause inside the hysteresis band, resume, then release and clear
	task automatic load_case(input logic ol, input logic [9:0] bad, input logic [9:0] band,
		input logic [9:0] good, input logic [7:0] exp);
		drive(ol, bad);
		cyc(70);
		drive(ol, band);
		cyc(200);
		alm("load_band", 8'hFF, 8'h00);
		drive(ol, bad);
		cyc(70);
		alm("load_expire", 8'hFF, exp);
		drive(ol, good);
		cyc(12);
		wr(A_CTRL, {23'h0, 1'b1, 6'h04, ol, ~ol});
		cyc(3);
		alm("load_clear", 8'hFF, 8'h00);
	endtask
	task automatic conclude;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Cuts a hung run short far beyond the few thousand cycles expected
	initial
	begin
		cyc(20000);
		failures++;
		conclude();
	end
	// Main sequence
	initial
	begin
		mset.sensor_temp = 13'sh00FA;
		mset.torque_pct = 10'h041;
		mset.motor_therm = 9'h096;
		mset.device_therm = 8'h4D;
		cyc(16);
		resetn <= 1'b1;
		cyc(3);
		rdchk("ctrl_rst", A_CTRL, 32'h0000_0010);
		rdchk("ul_rst", A_UL_CFG, 32'h0000_3C3C);
		rdchk("ol_rst", A_OL_CFG, 32'h0000_500A);
		rdchk("sens_rst", A_SENS_CFG, 32'h0000_0100);
		rdchk("lvl_rst", A_SENS_LVL, 32'h0384_044C);
		wr(8'h40, 32'hFFFF_FFFF);
		rdchk("unmapped", 8'h40, 32'h0000_0000);
		wr(A_UL_CFG, 32'h0001_3201);
		rdchk("ul_locked", A_UL_CFG, 32'h0000_3C3C);
		wr(A_CTRL, 32'h0000_0017);
		rdchk("cascade", A_CTRL, 32'h0000_0014);
		$display("test registers done");
		wr(A_CTRL, 32'h0000_0011);
		wr(A_UL_CFG, 32'h0000_0A01);
		rdchk("ul_thr_min", A_UL_CFG, 32'h0000_1401);
		mset.running <= 1'b1;
		mset.motor_active <= 1'b1;
		for (int r = 0; r < 2; r++)
		begin
			wr(A_UL_CFG, 32'h0000_3201 | (32'(r) << 16));
			rdchk("ul_resp", A_UL_CFG, 32'h0000_3201 | (32'(r) << 16));
			load_case(1'b0, 10'h028, 10'h037, 10'h041, r ? 8'h80 : 8'h40);
		end
		wr(A_CTRL, 32'h0000_0012);
		wr(A_OL_CFG, 32'h0003_FF01);
		rdchk("ol_thr_max", A_OL_CFG, 32'h0001_2C01);
		for (int r = 0; r < 2; r++)
		begin
			wr(A_OL_CFG, 32'h0000_5A01 | (32'(r) << 20));
			rdchk("ol_resp", A_OL_CFG, 32'h0000_5A01 | (32'(r) << 20));
			load_case(1'b1, 10'h064, 10'h055, 10'h046, r ? 8'h20 : 8'h10);
		end
		$display("test load done");
		wr(A_CTRL, 32'h0000_0028);
		for (int r = 0; r < 5; r++)
		begin
			wr(A_SENS_CFG, 32'h0000_1001 | (32'(r) << 8));
			mset.sensor_open <= 1'b1;
			cyc(40);
			alm("sens_resp", 8'h0B, sexp[r]);
			rdchk("temp_open", A_TEMP, 32'h0000_0812);
			mset.sensor_open <= 1'b0;
			cyc(4);
			wr(A_CTRL, 32'h0000_0128);
			cyc(3);
			alm("sens_clear", 8'hFF, 8'h00);
		end
		mset.sensor_short <= 1'b1;
		cyc(4);
		rdchk("temp_short", A_TEMP, 32'h0000_1EA2);
		mset.sensor_short <= 1'b0;
		// The brake ramp must end first: a fault reset while stopping is not taken
		cyc(20);
		alm("short_brake", 8'h0B, 8'h0B);
		wr(A_CTRL, 32'h0000_0118);
		rdchk("resp_kept", A_SENS_CFG, 32'h0000_1401);
		wr(A_SENS_CFG, 32'h0000_1101);
		mset.sensor_temp <= 13'sh047E;
		cyc(4);
		alm("lvl_trip", 8'hFF, 8'h0D);
		mset.sensor_temp <= 13'sh041A;
		cyc(4);
		wr(A_CTRL, 32'h0000_0118);
		cyc(3);
		alm("lvl_hold", 8'hFF, 8'h0D);
		mset.sensor_temp <= 13'sh0320;
		cyc(4);
		wr(A_CTRL, 32'h0000_0118);
		cyc(3);
		alm("lvl_release", 8'hFF, 8'h00);
		mset.sensor_temp <= 13'sh03B6;
		cyc(4);
		alm("warn_only", 8'hFF, 8'h04);
		wr(A_SENS_CFG, 32'h0000_0101);
		wr(A_CTRL, 32'h0000_0118);
		cyc(3);
		alm("warn_unassigned", 8'hFF, 8'h00);
		rdchk("therm", A_THERM, 32'h004D_0096);
		// Ten second filter: a step past the error level must not trip at once
		wr(A_SENS_CFG, 32'h0000_01A1);
		mset.sensor_temp <= 13'sh05DC;
		cyc(50);
		alm("filt_slow", 8'h0B, 8'h00);
		cyc(1500);
		alm("filt_settle", 8'h0B, 8'h09);
		$display("test sensor done");
		conclude();
	end
endmodule // plt_supervisor_test
